// File: pkg/dmc_pkg.sv
// Shared constants and types of the four-channel transfer controller.
// Assumes a single 125 MHz clock and synchronous pin inputs.
package dmc_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int NUM_CH     = 4;
  localparam int ADDR_W     = 24;
  localparam int DATA_W     = 16;
  localparam int CNT_W      = 16;
  localparam int FIFO_DEPTH = 16;

  typedef logic [ADDR_W-1:0] dmc_addr_t;
  typedef logic [DATA_W-1:0] dmc_data_t;
  typedef logic [CNT_W-1:0]  dmc_cnt_t;
  typedef logic [1:0]        dmc_prio_t;

  // ----------------------------------------------------------------
  // Transfer protocols and operand sizes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PROTO_EXP_ASYNC = 2'b00,
    PROTO_EXP_SLOW  = 2'b01,
    PROTO_IMP_ACK   = 2'b10,
    PROTO_IMP_RDY   = 2'b11
  } dmc_proto_t;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'b00,
    SZ_WORD = 2'b01,
    SZ_LONG = 2'b10,
    SZ_RSVD = 2'b11
  } dmc_size_t;

  // ----------------------------------------------------------------
  // Bus exception codes
  // ----------------------------------------------------------------
  localparam logic [2:0] BEC_NONE  = 3'h0;
  localparam logic [2:0] BEC_HALT  = 3'h1;
  localparam logic [2:0] BEC_BERR  = 3'h2;
  localparam logic [2:0] BEC_RETRY = 3'h3;

  // ----------------------------------------------------------------
  // Controller states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_REGACC = 3'b001,
    ST_ARB    = 3'b010,
    ST_ADR    = 3'b011,
    ST_STB    = 3'b100,
    ST_WAIT   = 3'b101,
    ST_REL    = 3'b110,
    ST_HALT   = 3'b111
  } dmc_state_t;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS      = 8;
  localparam int SLOW_STB_NS = 1000;
  localparam int SLOW_STB_CYC = (SLOW_STB_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] SLOW_STB_CNT = 8'(SLOW_STB_CYC);

endpackage

// File: pkg/dmc_fifo_if.sv
// Carrier between the controller and its operand FIFO.
// Assumes both ends share clk_sys.
`timescale 1ns/100ps
interface dmc_fifo_if #(parameter int W = 16);
  logic [W-1:0] in_data;
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] out_data;
  logic         out_valid;
  logic         out_ready;

  modport ctl (output in_data, in_valid, out_ready, input in_ready, out_data, out_valid);
  modport buf_side (input in_data, in_valid, out_ready, output in_ready, out_data, out_valid);
endinterface

// File: hdl/dmc_fifo.sv
// Operand FIFO that holds data between source read and destination write.
// Assumes an active-low reset whose release is already synchronised.
`timescale 1ns/100ps
module dmc_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic     clk_sys,
  input wire logic     rst_n,
  // Data path
  dmc_fifo_if.buf_side f
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  wire           push = f.in_valid & f.in_ready;
  wire           pop  = f.out_valid & f.out_ready;

  assign f.in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign f.out_valid = (cnt_q != '0);
  assign f.out_data  = mem_q[rd_q];

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_q[wr_q] <= f.in_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule // dmc_fifo

// File: hdl/dmc_top.sv
// Four-channel transfer controller: idle, register access and bus-master states.
// Assumes channel setup held on ports by the processor side; mode, size and device address are read throughout the transfer.
`timescale 1ns/100ps
module dmc_top (
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rstn,
  // Processor select
  input  wire logic                   cs_n,
  output logic                        reg_ack_n_q,
  // Channel setup
  input  wire logic [3:0]             ch_start,
  input  wire dmc_pkg::dmc_addr_t [3:0] ch_mem_addr,
  input  wire dmc_pkg::dmc_addr_t [3:0] ch_dev_addr,
  input  wire dmc_pkg::dmc_cnt_t  [3:0] ch_count,
  input  wire dmc_pkg::dmc_addr_t [3:0] ch_base_addr,
  input  wire dmc_pkg::dmc_cnt_t  [3:0] ch_base_count,
  input  wire logic [3:0]             ch_cont,
  input  wire dmc_pkg::dmc_prio_t [3:0] ch_prio,
  input  wire dmc_pkg::dmc_proto_t [3:0] ch_proto,
  input  wire dmc_pkg::dmc_size_t [3:0] ch_size,
  input  wire logic [3:0]             ch_port8,
  input  wire logic [3:0]             ch_to_dev,
  input  wire logic [3:0]             ch_auto,
  // Channel status
  output logic [3:0]                  ch_busy_q,
  output logic [3:0]                  ch_done_q,
  output logic [3:0]                  ch_err_q,
  // Bus arbitration
  output logic                        bus_req_n_q,
  input  wire logic                   bus_grant_n,
  input  wire logic                   as_in_n,
  // Master bus
  output dmc_pkg::dmc_addr_t          addr_q,
  output logic                        bus_oe_q,
  output logic                        as_n_q,
  output logic                        rw_q,
  output logic                        uds_n_q,
  output logic                        lds_n_q,
  input  wire dmc_pkg::dmc_data_t     data_in,
  output dmc_pkg::dmc_data_t          data_q,
  output logic                        data_oe_q,
  input  wire logic                   dtack_n,
  input  wire logic [2:0]             bec,
  // Device control
  input  wire logic [3:0]             req_n,
  output logic [3:0]                  ack_n_q,
  input  wire logic                   ready_n,
  output logic                        dtc_n_q
);
  import dmc_pkg::*;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_ff1_q;
  logic rst_n;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_ff1_q <= 1'b0;
      rst_n     <= 1'b0;
    end else begin
      rst_ff1_q <= 1'b1;
      rst_n     <= rst_ff1_q;
    end
  end

  // ----------------------------------------------------------------
  // Operand FIFO
  // ----------------------------------------------------------------
  dmc_fifo_if #(.W(DATA_W)) fq ();
  dmc_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .f       (fq)
  );

  dmc_state_t state_q;
  logic [1:0] sel_q;
  logic [1:0] last_q;
  logic       wr_phase_q;
  logic       redo_q;
  logic [2:0] beat_q;
  logic [2:0] beats_q;
  dmc_addr_t  cur_addr_q;
  logic [7:0] stb_cnt_q;
  logic       push_q;
  logic       pop_q;
  dmc_data_t  push_data_q;
  logic       op_done_q;
  logic       berr_q;

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  dmc_addr_t  maddr_q [NUM_CH];
  dmc_cnt_t   cnt_q   [NUM_CH];
  dmc_addr_t  baddr_q [NUM_CH];
  dmc_cnt_t   bcnt_q  [NUM_CH];
  logic [3:0] cont_q;
  logic [3:0] req_vec;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      wire        mine  = (sel_q == 2'(gi));
      wire  [2:0] bytes = 3'h1 << ch_size[gi];
      assign req_vec[gi] = ch_busy_q[gi] & (ch_auto[gi] | ~req_n[gi]);
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          maddr_q[gi]   <= '0;
          cnt_q[gi]     <= '0;
          baddr_q[gi]   <= '0;
          bcnt_q[gi]    <= '0;
          cont_q[gi]    <= 1'b0;
          ch_busy_q[gi] <= 1'b0;
          ch_done_q[gi] <= 1'b0;
          ch_err_q[gi]  <= 1'b0;
        end else if (ch_start[gi]) begin
          maddr_q[gi]   <= ch_mem_addr[gi];
          cnt_q[gi]     <= ch_count[gi];
          baddr_q[gi]   <= ch_base_addr[gi];
          bcnt_q[gi]    <= ch_base_count[gi];
          cont_q[gi]    <= ch_cont[gi];
          ch_busy_q[gi] <= (ch_count[gi] != '0);
          ch_done_q[gi] <= 1'b0;
          ch_err_q[gi]  <= (ch_count[gi] == '0);
        end else if (berr_q && mine) begin
          ch_busy_q[gi] <= 1'b0;
          ch_err_q[gi]  <= 1'b1;
        end else if (op_done_q && mine) begin
          maddr_q[gi] <= maddr_q[gi] + ADDR_W'(bytes);
          cnt_q[gi]   <= cnt_q[gi] - 1'b1;
          if (cnt_q[gi] == CNT_W'(1)) begin
            if (cont_q[gi] && bcnt_q[gi] != '0) begin
              maddr_q[gi] <= baddr_q[gi];
              cnt_q[gi]   <= bcnt_q[gi];
              cont_q[gi]  <= 1'b0;
            end else begin
              ch_busy_q[gi] <= 1'b0;
              ch_done_q[gi] <= 1'b1;
            end
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Priority pick: best level first, rotating among equals
  // ----------------------------------------------------------------
  function automatic logic [1:0] dmc_pick(input logic [3:0] req, input logic [7:0] pr,
                                          input logic [1:0] last);
    logic [1:0] best;
    logic [1:0] idx;
    logic       found;
    best     = 2'h3;
    found    = 1'b0;
    dmc_pick = last;
    for (int i = 0; i < 4; i++) begin
      if (req[i] && pr[2*i +: 2] < best) begin
        best = pr[2*i +: 2];
      end
    end
    for (int k = 1; k <= 4; k++) begin
      idx = last + 2'(k);
      if (!found && req[idx] && pr[2*idx +: 2] == best) begin
        dmc_pick = idx;
        found    = 1'b1;
      end
    end
  endfunction
  wire [1:0]  pick_ch  = dmc_pick(req_vec, ch_prio, last_q);
  wire        req_any  = |req_vec & ~op_done_q & ~berr_q;

  // ----------------------------------------------------------------
  // Decode of the selected channel
  // ----------------------------------------------------------------
  dmc_proto_t cur_proto;
  dmc_size_t  cur_size;
  assign cur_proto = ch_proto[sel_q];
  assign cur_size  = ch_size[sel_q];
  wire        cur_to_dev = ch_to_dev[sel_q];
  wire        cur_port8  = ch_port8[sel_q];
  wire        single     = cur_proto[1];
  wire        byte_beat  = cur_port8 | (cur_size == SZ_BYTE);
  wire [2:0]  op_bytes   = 3'h1 << cur_size;
  wire [2:0]  op_beats   = byte_beat ? op_bytes : (op_bytes >> 1);
  wire        cyc_rd     = single ? cur_to_dev : ~wr_phase_q;
  wire        use_dev    = ~single & (cur_to_dev == wr_phase_q);
  wire [23:0] cyc_addr   = use_dev ? ch_dev_addr[sel_q] : cur_addr_q;
  wire        a0         = cyc_addr[0];
  wire [7:0]  rd_byte    = a0 ? data_in[7:0] : data_in[15:8];
  wire [15:0] rd_word    = byte_beat ? {rd_byte, rd_byte} : data_in;
  wire [15:0] wr_word    = byte_beat ? {2{fq.out_data[7:0]}} : fq.out_data;
  wire        rdy_ok     = (cur_proto != PROTO_IMP_RDY) | ~ready_n;
  wire        slow_ok    = (cur_proto != PROTO_EXP_SLOW) | (stb_cnt_q == 8'h00);
  wire        term_ok    = ~dtack_n & rdy_ok & slow_ok;
  wire        adr_ok     = single | wr_phase_q | fq.in_ready;
  wire        last_beat  = (beat_q + 3'h1) >= beats_q;
  wire [23:0] beat_step  = byte_beat ? 24'h000001 : 24'h000002;

  assign fq.in_data   = push_data_q;
  assign fq.in_valid  = push_q;
  assign fq.out_ready = pop_q;

  // ----------------------------------------------------------------
  // Controller state machine
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q     <= ST_IDLE;
      sel_q       <= 2'h0;
      last_q      <= 2'h3;
      wr_phase_q  <= 1'b0;
      redo_q      <= 1'b0;
      beat_q      <= 3'h0;
      beats_q     <= 3'h1;
      cur_addr_q  <= '0;
      stb_cnt_q   <= 8'h00;
      push_q      <= 1'b0;
      pop_q       <= 1'b0;
      push_data_q <= '0;
      op_done_q   <= 1'b0;
      berr_q      <= 1'b0;
      reg_ack_n_q <= 1'b1;
      bus_req_n_q <= 1'b1;
      addr_q      <= '0;
      bus_oe_q    <= 1'b0;
      as_n_q      <= 1'b1;
      rw_q        <= 1'b1;
      uds_n_q     <= 1'b1;
      lds_n_q     <= 1'b1;
      data_q      <= '0;
      data_oe_q   <= 1'b0;
      ack_n_q     <= 4'hf;
      dtc_n_q     <= 1'b1;
    end else begin
      push_q    <= 1'b0;
      pop_q     <= 1'b0;
      op_done_q <= 1'b0;
      berr_q    <= 1'b0;
      dtc_n_q   <= 1'b1;
      if (stb_cnt_q != 8'h00) begin
        stb_cnt_q <= stb_cnt_q - 8'h01;
      end
      unique case (state_q)
        ST_IDLE: begin
          if (!cs_n) begin
            state_q     <= ST_REGACC;
            reg_ack_n_q <= 1'b0;
          end else if (req_any) begin
            state_q     <= ST_ARB;
            sel_q       <= pick_ch;
            bus_req_n_q <= 1'b0;
          end
        end
        ST_REGACC: begin
          if (cs_n) begin
            state_q     <= ST_IDLE;
            reg_ack_n_q <= 1'b1;
          end
        end
        ST_ARB: begin
          if (!bus_grant_n && as_in_n) begin
            state_q    <= ST_ADR;
            last_q     <= sel_q;
            cur_addr_q <= maddr_q[sel_q];
            beats_q    <= op_beats;
            beat_q     <= 3'h0;
            wr_phase_q <= 1'b0;
            bus_oe_q   <= 1'b1;
          end
        end
        ST_ADR: begin
          if (adr_ok) begin
            state_q   <= ST_STB;
            addr_q    <= cyc_addr;
            rw_q      <= cyc_rd;
            as_n_q    <= 1'b0;
            stb_cnt_q <= SLOW_STB_CNT;
          end
        end
        ST_STB: begin
          state_q <= ST_WAIT;
          uds_n_q <= byte_beat & a0;
          lds_n_q <= byte_beat & ~a0;
          if (single) begin
            ack_n_q[sel_q] <= 1'b0;
          end else if (!cyc_rd) begin
            data_q    <= wr_word;
            data_oe_q <= 1'b1;
          end
        end
        ST_WAIT: begin
          if (bec == BEC_HALT) begin
            state_q <= ST_HALT;
          end else if (bec == BEC_BERR) begin
            state_q     <= ST_IDLE;
            berr_q      <= 1'b1;
            pop_q       <= ~single & ~cyc_rd;
            bus_req_n_q <= 1'b1;
            bus_oe_q    <= 1'b0;
          end else if (bec == BEC_RETRY) begin
            state_q <= ST_REL;
            redo_q  <= 1'b1;
          end else if (term_ok) begin
            state_q <= ST_REL;
            redo_q  <= 1'b0;
            if (!single && cyc_rd) begin
              push_q      <= 1'b1;
              push_data_q <= rd_word;
            end
            if (!single && !cyc_rd) begin
              pop_q <= 1'b1;
            end
            if (single || !cyc_rd) begin
              dtc_n_q <= 1'b0;
            end
          end
          if (bec != BEC_NONE || term_ok) begin
            as_n_q    <= 1'b1;
            uds_n_q   <= 1'b1;
            lds_n_q   <= 1'b1;
            data_oe_q <= 1'b0;
            ack_n_q   <= 4'hf;
          end
        end
        ST_HALT: begin
          if (bec != BEC_HALT) begin
            state_q <= ST_ADR;
          end
        end
        ST_REL: begin
          if (redo_q) begin
            state_q <= ST_ADR;
          end else if (!single && !wr_phase_q) begin
            state_q    <= ST_ADR;
            wr_phase_q <= 1'b1;
          end else if (!last_beat) begin
            state_q    <= ST_ADR;
            beat_q     <= beat_q + 3'h1;
            wr_phase_q <= 1'b0;
            cur_addr_q <= cur_addr_q + beat_step;
          end else begin
            state_q     <= ST_IDLE;
            op_done_q   <= 1'b1;
            bus_req_n_q <= 1'b1;
            bus_oe_q    <= 1'b0;
          end
        end
      endcase
    end
  end
endmodule // dmc_top

// File: verif/dmc_chk.sv
// Port checker of the transfer controller.
// Assumes it is bound into dmc_top and sees only that module's ports.
`timescale 1ns/100ps
module dmc_chk (
  // Clock and reset
  input wire logic                clk_sys,
  input wire logic                rstn,
  // Processor side
  input wire logic                cs_n,
  input wire logic                reg_ack_n_q,
  input wire logic [3:0]          ch_start,
  input wire logic [3:0]          ch_busy_q,
  input wire logic [3:0]          ch_done_q,
  input wire logic [3:0]          ch_err_q,
  // Master bus
  input wire logic                bus_req_n_q,
  input wire logic                bus_oe_q,
  input wire logic                as_n_q,
  input wire logic                uds_n_q,
  input wire logic                lds_n_q,
  input wire dmc_pkg::dmc_addr_t  addr_q,
  input wire dmc_pkg::dmc_data_t  data_q,
  input wire logic                data_oe_q,
  input wire logic [2:0]          bec,
  // Device control
  input wire logic [3:0]          ack_n_q,
  input wire logic                dtc_n_q
);
  import dmc_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence s_cs_dropped;
    !reg_ack_n_q && cs_n;
  endsequence
  sequence s_released;
    as_n_q && uds_n_q && lds_n_q;
  endsequence
  chk_reset_quiet: assert property ($rose(rstn) |-> (bus_req_n_q && as_n_q && reg_ack_n_q && ch_busy_q == 4'h0)[*2])
    else $error("controller active right after reset");
  chk_regacc_free: assert property (s_cs_dropped |=> reg_ack_n_q)
    else $error("register access outlives chip select");
  chk_regacc_cause: assert property (!reg_ack_n_q |-> $past(!cs_n))
    else $error("register access without chip select");
  chk_one_state: assert property (!reg_ack_n_q |-> bus_req_n_q && !bus_oe_q)
    else $error("register access while bus master");
  chk_master_strobe: assert property (!as_n_q |-> bus_oe_q && !bus_req_n_q)
    else $error("address strobe without bus mastership");
  chk_single_ack: assert property (ack_n_q != 4'hf |-> $onehot(~ack_n_q) && bus_oe_q)
    else $error("device acknowledge outside a single master cycle");
  chk_dtc_pulse: assert property (!dtc_n_q |=> dtc_n_q)
    else $error("transfer complete pulse too long");
  chk_write_hold: assert property (data_oe_q && $past(data_oe_q) |-> $stable(data_q))
    else $error("held operand changed during write");
  chk_byte_lane: assert property (!as_n_q && (uds_n_q != lds_n_q) |-> uds_n_q == addr_q[0])
    else $error("byte strobe on wrong lane");
  chk_status_excl: assert property ((ch_busy_q & (ch_done_q | ch_err_q)) == 4'h0)
    else $error("channel busy and finished at once");
  chk_start_answer: assert property (ch_start != 4'h0 |=> ((ch_busy_q | ch_err_q) & $past(ch_start)) == $past(ch_start))
    else $error("started channel neither busy nor in error");
  chk_berr_release: assert property (bec == BEC_BERR && !as_n_q |-> ##[1:4] s_released)
    else $error("bus error did not release the strobes");
endmodule // dmc_chk

bind dmc_top dmc_chk i_dmc_chk (.clk_sys(clk_sys), .rstn(rstn), .cs_n(cs_n), .reg_ack_n_q(reg_ack_n_q),
  .ch_start(ch_start), .ch_busy_q(ch_busy_q), .ch_done_q(ch_done_q), .ch_err_q(ch_err_q),
  .bus_req_n_q(bus_req_n_q), .bus_oe_q(bus_oe_q), .as_n_q(as_n_q), .uds_n_q(uds_n_q), .lds_n_q(lds_n_q),
  .addr_q(addr_q), .data_q(data_q), .data_oe_q(data_oe_q), .bec(bec), .ack_n_q(ack_n_q), .dtc_n_q(dtc_n_q));

// File: verif/dmc_bus_partner.sv
// Memory, arbiter and device model on the far side of the master bus.
// Assumes the bench seeds the read pattern and picks exceptions by name.
`timescale 1ns/100ps
module dmc_bus_partner (
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rstn,
  // Arbitration
  input  wire logic                bus_req_n_q,
  output logic                     bus_grant_n,
  output logic                     as_in_n,
  // Master bus
  input  wire logic                as_n_q,
  input  wire logic                rw_q,
  input  wire logic                uds_n_q,
  input  wire logic                lds_n_q,
  input  wire dmc_pkg::dmc_addr_t  addr_q,
  input  wire dmc_pkg::dmc_data_t  data_q,
  output dmc_pkg::dmc_data_t       data_in,
  output logic                     dtack_n,
  output logic [2:0]               bec,
  // Device control
  input  wire logic [3:0]          ack_n_q,
  output logic                     ready_n
);
  import dmc_pkg::*;
  logic [40:0] log_q[$];
  dmc_data_t   key;
  dmc_data_t   dev_word;
  logic [2:0]  exc;
  int          exc_cnt;
  int          lat;
  wire         strobe = !as_n_q && !(uds_n_q && lds_n_q);
  wire         dev_on = ack_n_q != 4'hf;
  initial begin
    {bus_grant_n, as_in_n, dtack_n, ready_n} = 4'hf;
    {bec, exc, data_in} = '0;
    exc_cnt = 0;
    lat = 0;
  end
  always @(posedge clk_sys) begin
    #1;
    bus_grant_n <= bus_req_n_q | !rstn;
    ready_n <= !dev_on;
    // A released bus never keeps its last value
    if (dev_on && !rw_q) data_in <= dev_word;
    else if (strobe && rw_q) data_in <= addr_q[15:0] ^ key;
    else data_in <= ~data_in;
    if (exc_cnt != 0) begin
      exc_cnt--;
      bec <= (exc_cnt == 0) ? BEC_NONE : exc;
      if (exc_cnt == 0) exc = BEC_NONE;
    end else if (strobe && dtack_n && exc != BEC_NONE) begin
      exc_cnt = 4;
      bec <= exc;
    end else if (!strobe) begin
      dtack_n <= 1'b1;
      lat = $urandom_range(3);
    end else if (lat != 0) lat--;
    else if (dtack_n) begin
      dtack_n <= 1'b0;
      log_q.push_back({rw_q, addr_q, rw_q ? addr_q[15:0] ^ key : (dev_on ? dev_word : data_q)});
    end
  end
endmodule // dmc_bus_partner

// File: verif/dma_mode_and_transfer_control_tb_top.sv
// Self-checking bench of the transfer controller with a bus partner.
// Assumes the partner logs every completed master cycle.
`timescale 1ns/100ps
module dma_mode_and_transfer_control_tb_top;
  import dmc_pkg::*;
  logic clk_sys, rstn, cs_n, reg_ack_n_q, bus_req_n_q, bus_grant_n, as_in_n, bus_oe_q, as_n_q, rw_q;
  logic uds_n_q, lds_n_q, data_oe_q, dtack_n, ready_n, dtc_n_q;
  logic [3:0]      ch_start, ch_cont, ch_port8, ch_to_dev, ch_auto, ch_busy_q, ch_done_q, ch_err_q, req_n, ack_n_q;
  dmc_addr_t [3:0] ch_mem_addr, ch_dev_addr, ch_base_addr;
  dmc_cnt_t  [3:0] ch_count, ch_base_count;
  dmc_prio_t [3:0] ch_prio;
  dmc_proto_t [3:0] ch_proto;
  dmc_size_t [3:0] ch_size;
  dmc_addr_t       addr_q;
  dmc_data_t       data_in, data_q, key, dev_word;
  logic [2:0]      bec;
  logic [40:0]     exp_q[$];
  int              bad_count, checks_done, p, k;
  dmc_top i_dmc_top (.clk_sys(clk_sys), .rstn(rstn), .cs_n(cs_n), .reg_ack_n_q(reg_ack_n_q), .ch_start(ch_start),
    .ch_mem_addr(ch_mem_addr), .ch_dev_addr(ch_dev_addr), .ch_count(ch_count), .ch_base_addr(ch_base_addr),
    .ch_base_count(ch_base_count), .ch_cont(ch_cont), .ch_prio(ch_prio), .ch_proto(ch_proto), .ch_size(ch_size),
    .ch_port8(ch_port8), .ch_to_dev(ch_to_dev), .ch_auto(ch_auto), .ch_busy_q(ch_busy_q), .ch_done_q(ch_done_q),
    .ch_err_q(ch_err_q), .bus_req_n_q(bus_req_n_q), .bus_grant_n(bus_grant_n), .as_in_n(as_in_n), .addr_q(addr_q),
    .bus_oe_q(bus_oe_q), .as_n_q(as_n_q), .rw_q(rw_q), .uds_n_q(uds_n_q), .lds_n_q(lds_n_q), .data_in(data_in),
    .data_q(data_q), .data_oe_q(data_oe_q), .dtack_n(dtack_n), .bec(bec), .req_n(req_n), .ack_n_q(ack_n_q),
    .ready_n(ready_n), .dtc_n_q(dtc_n_q));
  dmc_bus_partner i_dmc_bus_partner (.clk_sys(clk_sys), .rstn(rstn), .bus_req_n_q(bus_req_n_q),
    .bus_grant_n(bus_grant_n), .as_in_n(as_in_n), .as_n_q(as_n_q), .rw_q(rw_q), .uds_n_q(uds_n_q), .lds_n_q(lds_n_q),
    .addr_q(addr_q), .data_q(data_q), .data_in(data_in), .dtack_n(dtack_n), .bec(bec), .ack_n_q(ack_n_q),
    .ready_n(ready_n));
  // ----------------------------------------------------------------
  // Checking and model
  // ----------------------------------------------------------------
  task automatic check(input logic [40:0] seen, input logic [40:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Expected bus cycles of one block: per beat, dual read then write, or one single cycle
  task automatic model(input int c, input dmc_addr_t a, input int n);
    int i, nb, step;
    dmc_addr_t m;
    dmc_data_t w;
    nb = ch_port8[c] ? (1 << ch_size[c]) : ((ch_size[c] == SZ_LONG) ? 2 : 1);
    step = (ch_port8[c] || ch_size[c] == SZ_BYTE) ? 1 : 2;
    for (i = 0; i < n * nb; i++) begin
      m = a + 24'(i * step);
      w = m[15:0] ^ key;
      if (ch_proto[c][1]) exp_q.push_back({1'b0, m, dev_word});
      else begin
        exp_q.push_back({1'b1, m, w});
        if (step == 1) w = m[0] ? {2{w[7:0]}} : {2{w[15:8]}};
        exp_q.push_back({1'b0, ch_dev_addr[c], w});
      end
    end
  endtask
  task automatic match(input string name);
    int i;
    check(41'(i_dmc_bus_partner.log_q.size()), 41'(exp_q.size()));
    for (i = 0; i < exp_q.size() && i < i_dmc_bus_partner.log_q.size(); i++) begin
      check(i_dmc_bus_partner.log_q[i], exp_q[i]);
    end
    exp_q.delete();
    i_dmc_bus_partner.log_q.delete();
    $display("test %s finished", name);
  endtask
  task automatic setch(input int c, input dmc_proto_t pr, input dmc_size_t s, input int n);
    ch_proto[c] = pr;
    ch_size[c] = s;
    ch_count[c] = 16'(n);
    ch_to_dev[c] = !pr[1];
    ch_port8[c] = pr == PROTO_IMP_RDY;
    ch_auto[c] = !pr[1];
    req_n[c] = !pr[1];
    ch_mem_addr[c] = 24'($urandom & 32'hffff0) + 24'(s == SZ_BYTE);
    ch_dev_addr[c] = 24'h800000 + 24'($urandom_range(255) * 2);
  endtask
  task automatic go(input logic [3:0] m);
    int n;
    ch_start = m;
    @(posedge clk_sys) #1 ch_start = 4'h0;
    for (n = 0; n < 20000 && (ch_busy_q & m) !== 4'h0; n++) @(posedge clk_sys) #1;
  endtask
  // ----------------------------------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    #400000;
    bad_count++;
    summarize();
  end
  initial begin
    void'($urandom(5));
    rstn = 1'b0;
    {cs_n, ch_start, ch_cont, ch_port8, ch_to_dev, ch_auto, req_n} = {1'b1, 20'h0, 4'hf};
    {ch_mem_addr, ch_dev_addr, ch_base_addr, ch_count, ch_base_count, ch_prio, ch_proto, ch_size} = '0;
    key = 16'($urandom);
    dev_word = 16'($urandom);
    i_dmc_bus_partner.key = key;
    i_dmc_bus_partner.dev_word = dev_word;
    repeat (16) @(posedge clk_sys);
    #1 rstn = 1'b1;
    repeat (3) @(posedge clk_sys) #1;
    check(41'({bus_req_n_q, as_n_q, reg_ack_n_q, dtc_n_q, bus_oe_q, data_oe_q, ch_busy_q, ch_done_q, ch_err_q, ack_n_q}),
          41'h3c000f);
    match("reset");
    cs_n = 1'b0;
    repeat (2) @(posedge clk_sys) #1;
    check(41'(reg_ack_n_q), 41'h0);
    cs_n = 1'b1;
    repeat (2) @(posedge clk_sys) #1;
    check(41'(reg_ack_n_q), 41'h1);
    match("register access");
    for (p = 0; p < 4; p++) begin
      setch(p, dmc_proto_t'(p), p == 0 ? SZ_LONG : (p == 1 ? SZ_BYTE : SZ_WORD), 1 + $urandom_range(2));
      i_dmc_bus_partner.exc = p == 0 ? BEC_RETRY : (p == 2 ? BEC_HALT : BEC_NONE);
      model(p, ch_mem_addr[p], ch_count[p]);
      go(4'h1 << p);
      check(41'(ch_done_q[p]), 41'h1);
      match("protocol");
    end
    setch(0, PROTO_EXP_ASYNC, SZ_WORD, 0);
    go(4'h1);
    check(41'({ch_err_q[0], ch_busy_q[0]}), 41'h2);
    match("zero count");
    setch(1, PROTO_EXP_ASYNC, SZ_WORD, 2);
    i_dmc_bus_partner.exc = BEC_BERR;
    go(4'h2);
    check(41'({ch_err_q[1], ch_busy_q[1]}), 41'h2);
    match("bus error");
    setch(2, PROTO_EXP_ASYNC, SZ_WORD, 2);
    ch_cont[2] = 1'b1;
    ch_base_addr[2] = 24'($urandom & 32'hffff0);
    ch_base_count[2] = 16'h1;
    model(2, ch_mem_addr[2], 2);
    model(2, ch_base_addr[2], 1);
    go(4'h4);
    ch_cont[2] = 1'b0;
    check(41'(ch_done_q[2]), 41'h1);
    match("continue");
    for (p = 0; p < 4; p++) setch(p, PROTO_EXP_ASYNC, SZ_WORD, 1);
    ch_prio = {2'd1, 2'd3, 2'd0, 2'd2};
    model(1, ch_mem_addr[1], 1);
    model(3, ch_mem_addr[3], 1);
    model(0, ch_mem_addr[0], 1);
    model(2, ch_mem_addr[2], 1);
    go(4'hf);
    match("priority");
    setch(0, PROTO_EXP_ASYNC, SZ_WORD, 2);
    setch(1, PROTO_EXP_ASYNC, SZ_WORD, 2);
    ch_prio = '0;
    for (k = 0; k < 2; k++) begin
      model(0, ch_mem_addr[0] + 24'(2 * k), 1);
      model(1, ch_mem_addr[1] + 24'(2 * k), 1);
    end
    go(4'h3);
    match("round robin");
    summarize();
  end
endmodule // dma_mode_and_transfer_control_tb_top
